/* src/ufc_pkg.sv */
// Package for the UART flow-control and packet-end option block.
// Assumes a single bus clock; register indices are word offsets on the slave port.
package ufc_pkg;
  // Register word offsets.
  localparam logic [2:0] ADDR_RXDATA = 3'h0;
  localparam logic [2:0] ADDR_TXDATA = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_CONTROL = 3'h3;
  localparam logic [2:0] ADDR_PACKET_END = 3'h5;
  // Status bit positions.
  localparam int ST_PE = 0;
  localparam int ST_FE = 1;
  localparam int ST_BRK = 2;
  localparam int ST_ROE = 3;
  localparam int ST_RRDY = 7;
  localparam int ST_E = 8;
  localparam int ST_DCTS = 10;
  localparam int ST_CTS = 11;
  localparam int ST_EOP = 12;
  // Control bit positions.
  localparam int CT_IDCTS = 10;
  localparam int CT_RTS = 11;
  localparam int CT_PACKET_END_IRQ_ENABLE = 12;
  // Reset values.
  localparam logic [8:0] PACKET_END_RESET = 9'h000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
endpackage : ufc_pkg

/* src/ufc_core.sv */
// Flow-control and packet-end register logic of a memory-mapped UART.
// Assumes the receive shifter supplies characters and error pulses on the bus clock.
//
// Overview of operation
// - Optional active-low clear and request pins.
// - Status carries cts level and change.
// - Pins touch only their register bits.
// - Without option those bits read zero.
// - Stream ready and data-available signals.
// - Packet-end register at word five.
// - Packet-end status, enable, sideband signal.
// - Matching received character asserts end-of-packet.
// - Without option packet-end writes ignored.
// - Writing zero to status clears sticky flags.
// - Receive-ready set on character, cleared on read.
`timescale 1ns/10ps
`default_nettype none
module ufc_core #(
  parameter int DATA_BITS = 8,
  parameter bit HAS_FLOW = 1'b1,
  parameter bit HAS_EOP = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] address_i,
  input wire logic chipselect_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [15:0] writedata_i,
  output logic [15:0] readdata_o,
  output logic readyfordata_o,
  output logic dataavailable_o,
  output logic endofpacket_o,
  output logic irq_o,
  input wire logic cts_n_i,
  output logic rts_n_o,
  input wire logic rx_char_valid_i,
  input wire logic [DATA_BITS-1:0] rx_char_i,
  input wire logic rx_frame_err_i,
  input wire logic rx_parity_err_i,
  input wire logic rx_break_i,
  input wire logic tx_ready_i,
  output logic tx_write_o,
  output logic [DATA_BITS-1:0] tx_char_o
);
  // ***************************************
  // Functions.
  // ***************************************
  // Next value of a sticky flag.
  // A new event beats a clear in the same cycle, so no event is ever lost.
  function automatic logic ufc_sticky(input logic set, input logic held, input logic clr);
    ufc_sticky = set || (held && !clr);
  endfunction : ufc_sticky
  // ***************************************
  // Decode.
  // ***************************************
  logic [DATA_BITS-1:0] rx_data;
  logic [DATA_BITS-1:0] packet_end;
  logic [15:0] control;
  logic rrdy;
  logic roe;
  logic fe;
  logic pe;
  logic brk;
  logic dcts;
  logic eop;
  logic cts_s1;
  logic cts_s2;
  logic cts_d;
  wire acc_wr = ce_i && chipselect_i && write_i;
  wire acc_rd = ce_i && chipselect_i && read_i;
  wire wr_status = acc_wr && (address_i == ufc_pkg::ADDR_STATUS);
  wire wr_control = acc_wr && (address_i == ufc_pkg::ADDR_CONTROL);
  wire wr_pe_reg = acc_wr && HAS_EOP && (address_i == ufc_pkg::ADDR_PACKET_END);
  wire wr_tx = acc_wr && (address_i == ufc_pkg::ADDR_TXDATA);
  wire rd_rx = acc_rd && (address_i == ufc_pkg::ADDR_RXDATA);
  wire clr_sticky = wr_status && (writedata_i == 16'h0000);
  wire eop_match = HAS_EOP && rx_char_valid_i && (rx_char_i == packet_end);
  wire cts_edge = HAS_FLOW && (cts_s2 != cts_d);
  // The pin is active low, so the level bit reads one while the pin is low.
  wire cts_level = HAS_FLOW && !cts_s2;
  wire err_any = roe || fe || pe || brk;
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[ufc_pkg::ST_PE] = pe;
    status[ufc_pkg::ST_FE] = fe;
    status[ufc_pkg::ST_BRK] = brk;
    status[ufc_pkg::ST_ROE] = roe;
    status[ufc_pkg::ST_RRDY] = rrdy;
    status[ufc_pkg::ST_E] = err_any;
    status[ufc_pkg::ST_DCTS] = HAS_FLOW && dcts;
    status[ufc_pkg::ST_CTS] = cts_level;
    status[ufc_pkg::ST_EOP] = HAS_EOP && eop;
  end
  // Read data reloads on every enabled cycle, which is cheaper than a load
  // qualified by the read strobe; a master must take it in the cycle after its read.
  logic [15:0] next_readdata;
  always_comb begin
    next_readdata = 16'h0000;
    if (address_i == ufc_pkg::ADDR_RXDATA) begin
      next_readdata[DATA_BITS-1:0] = rx_data;
    end else if (address_i == ufc_pkg::ADDR_STATUS) begin
      next_readdata = status;
    end else if (address_i == ufc_pkg::ADDR_CONTROL) begin
      next_readdata = control;
    end else if (address_i == ufc_pkg::ADDR_PACKET_END && HAS_EOP) begin
      next_readdata[DATA_BITS-1:0] = packet_end;
    end
  end
  // ***************************************
  // Registers.
  // ***************************************
  // Two-stage pin synchroniser.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Reset to the idle level of the pin, so no false change follows reset.
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
      cts_d <= 1'b1;
    end else if (ce_i) begin
      cts_s1 <= cts_n_i;
      cts_s2 <= cts_s1;
      cts_d <= cts_s2;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= ufc_pkg::CONTROL_RESET;
      packet_end <= ufc_pkg::PACKET_END_RESET[DATA_BITS-1:0];
    end else begin
      if (wr_control) begin
        control <= writedata_i;
        control[ufc_pkg::CT_IDCTS] <= HAS_FLOW && writedata_i[ufc_pkg::CT_IDCTS];
        control[ufc_pkg::CT_RTS] <= HAS_FLOW && writedata_i[ufc_pkg::CT_RTS];
        control[ufc_pkg::CT_PACKET_END_IRQ_ENABLE] <= HAS_EOP && writedata_i[ufc_pkg::CT_PACKET_END_IRQ_ENABLE];
      end
      if (wr_pe_reg) begin
        packet_end <= writedata_i[DATA_BITS-1:0];
      end
    end
  end
  // Set terms win over the zero-write clear so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rrdy <= 1'b0;
      roe <= 1'b0;
      fe <= 1'b0;
      pe <= 1'b0;
      brk <= 1'b0;
      dcts <= 1'b0;
      eop <= 1'b0;
      rx_data <= '0;
    end else if (ce_i) begin
      if (rx_char_valid_i) begin
        rx_data <= rx_char_i;
        rrdy <= 1'b1;
      end else if (rd_rx) begin
        rrdy <= 1'b0;
      end
      // A character landing on an unread one is an overrun.
      roe <= ufc_sticky(rx_char_valid_i && rrdy, roe, clr_sticky);
      fe <= ufc_sticky(rx_frame_err_i, fe, clr_sticky);
      pe <= ufc_sticky(rx_parity_err_i, pe, clr_sticky);
      brk <= ufc_sticky(rx_break_i, brk, clr_sticky);
      dcts <= ufc_sticky(cts_edge, dcts, clr_sticky);
      // Packet-end flag, cleared by rxdata read.
      // Clearing on the data read lets a DMA master end one packet and start the next.
      eop <= ufc_sticky(eop_match, eop, rd_rx || clr_sticky);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      readdata_o <= 16'h0000;
      tx_char_o <= '0;
      tx_write_o <= 1'b0;
    end else if (ce_i) begin
      readdata_o <= next_readdata;
      tx_write_o <= wr_tx;
      if (wr_tx) begin
        tx_char_o <= writedata_i[DATA_BITS-1:0];
      end
    end
  end
  // ***************************************
  // Outputs.
  // ***************************************
  // Rts only from its bit.
  // With the option left out the pin parks high, its inactive level.
  assign rts_n_o = !(HAS_FLOW && control[ufc_pkg::CT_RTS]);
  assign readyfordata_o = tx_ready_i;
  assign dataavailable_o = rrdy;
  assign endofpacket_o = HAS_EOP && eop;
  // ***************************************
  // Interrupt.
  // ***************************************
  // Change interrupt term.
  wire irq_cts = dcts && control[ufc_pkg::CT_IDCTS];
  wire irq_eop = eop && control[ufc_pkg::CT_PACKET_END_IRQ_ENABLE];
  // The request is a level and drops as soon as its flag is cleared.
  assign irq_o = irq_cts || irq_eop;
endmodule : ufc_core
`default_nettype wire

/* sim/ufc_core_sva.sv */
// Port checker for ufc_core.
// Assumes one bus clock with a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ufc_core_sva #(
  parameter int DATA_BITS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] address_i,
  input wire logic chipselect_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [15:0] writedata_i,
  input wire logic [15:0] readdata_o,
  input wire logic readyfordata_o,
  input wire logic dataavailable_o,
  input wire logic endofpacket_o,
  input wire logic rts_n_o,
  input wire logic rx_char_valid_i,
  input wire logic tx_ready_i,
  input wire logic tx_write_o,
  input wire logic [DATA_BITS-1:0] tx_char_o
);
  wire logic wr = ce_i && chipselect_i && write_i;
  wire logic rd = ce_i && chipselect_i && read_i;
  wire logic ctl_wr = wr && address_i == ufc_pkg::ADDR_CONTROL;
  wire logic tx_req = wr && address_i == ufc_pkg::ADDR_TXDATA;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ready_follows_a: assert property (readyfordata_o == tx_ready_i)
    else $error("ready differs");
  rx_avail_a: assert property (ce_i && rx_char_valid_i |=> dataavailable_o)
    else $error("no data available");
  rx_read_a: assert property (rd && address_i == ufc_pkg::ADDR_RXDATA && !rx_char_valid_i
    |=> !dataavailable_o && !endofpacket_o) else $error("read left flags");
  rts_write_a: assert property (ctl_wr |=> rts_n_o == !$past(writedata_i[ufc_pkg::CT_RTS]))
    else $error("rts pin wrong");
  rts_hold_a: assert property (!ctl_wr |=> $stable(rts_n_o))
    else $error("rts pin moved");
  rts_reset_a: assert property ($fell(rst_i) |-> rts_n_o)
    else $error("rts not idle");
  tx_write_a: assert property (tx_req |=> tx_write_o && tx_char_o == $past(writedata_i[DATA_BITS-1:0]))
    else $error("tx write wrong");
  tx_cause_a: assert property (tx_write_o && $past(ce_i) |-> $past(tx_req))
    else $error("tx write uncaused");
  unmapped_read_a: assert property (rd && (address_i == 3'h4 || address_i > 3'h5)
    |=> readdata_o == 16'h0000) else $error("unmapped read");
endmodule : ufc_core_sva
bind ufc_core ufc_core_sva #(.DATA_BITS(DATA_BITS)) ufc_core_sva_inst (.*);
`default_nettype wire

/* sim/ufc_term.sv */
// Shifter-side stand-in: delivers received characters and stalls the transmitter.
// Assumes the bench asks for one character at a time.
`timescale 1ns/10ps
`default_nettype none
module ufc_term (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic send_i,
  input wire logic [7:0] char_i,
  input wire logic tx_write_i,
  output logic rx_valid_o,
  output logic [7:0] rx_char_o,
  output logic tx_ready_o
);
  logic [1:0] busy;
  assign tx_ready_o = busy == 2'h0;
  always_ff @(posedge clk_i) begin
    busy <= rst_i ? 2'h0 : tx_write_i ? 2'h3 : busy - {1'b0, busy != 2'h0};
    rx_valid_o <= send_i && !rst_i;
    // Outside a delivery the data lines toggle so stale values are never trusted.
    rx_char_o <= send_i ? char_i : ~rx_char_o;
  end
endmodule : ufc_term
`default_nettype wire

/* sim/tb_ufc_core.sv */
// Self-checking bench for ufc_core registers, pins and stream signals.
// Assumes the checker is bound in and ufc_term serves the shifter side.
`timescale 1ns/10ps
`default_nettype none
module tb_ufc_core;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic chipselect_i = 1'b0, read_i = 1'b0, write_i = 1'b0, send = 1'b0, cts_n_i = 1'b1;
  logic rx_frame_err_i = 1'b0, rx_parity_err_i = 1'b0, rx_break_i = 1'b0;
  logic readyfordata_o, dataavailable_o, endofpacket_o, irq_o, rts_n_o;
  logic tx_write_o, tx_ready_i, rx_char_valid_i;
  logic [2:0] address_i = 3'h0;
  logic [7:0] rx_char_i, tx_char_o, char = 8'h00;
  logic [15:0] writedata_i = 16'h0000, readdata_o, rd_v;
  int n_fail = 0;
  int tests_run = 0;
  always #20 clk_i = ~clk_i;
  ufc_core ufc_core_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .address_i(address_i),
    .chipselect_i(chipselect_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .readyfordata_o(readyfordata_o), .dataavailable_o(dataavailable_o),
    .endofpacket_o(endofpacket_o), .irq_o(irq_o), .cts_n_i(cts_n_i), .rts_n_o(rts_n_o),
    .rx_char_valid_i(rx_char_valid_i), .rx_char_i(rx_char_i), .rx_frame_err_i(rx_frame_err_i),
    .rx_parity_err_i(rx_parity_err_i), .rx_break_i(rx_break_i), .tx_ready_i(tx_ready_i),
    .tx_write_o(tx_write_o), .tx_char_o(tx_char_o));
  ufc_term ufc_term_inst (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .char_i(char),
    .tx_write_i(tx_write_o), .rx_valid_o(rx_char_valid_i), .rx_char_o(rx_char_i),
    .tx_ready_o(tx_ready_i));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    chipselect_i <= 1'b1;
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    @(posedge clk_i);
    chipselect_i <= 1'b0;
    read_i <= 1'b0;
    write_i <= 1'b0;
    #1 rd_v = readdata_o;
  endtask : bus
  task automatic rx(input logic [7:0] c);
    @(posedge clk_i);
    send <= 1'b1;
    char <= c;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : rx
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, ufc_pkg::ADDR_CONTROL, 16'h1C00);
    chk("rts", 16'h0000, {15'h0000, rts_n_o});
    bus(1'b0, ufc_pkg::ADDR_CONTROL, 16'h0000);
    chk("control", 16'h1C00, rd_v);
    bus(1'b1, ufc_pkg::ADDR_PACKET_END, 16'h005A);
    bus(1'b0, ufc_pkg::ADDR_PACKET_END, 16'h0000);
    chk("packet end", 16'h005A, rd_v);
    rx(8'h41);
    chk("eop", 16'h0000, {15'h0000, endofpacket_o});
    bus(1'b0, ufc_pkg::ADDR_RXDATA, 16'h0000);
    chk("rxdata", 16'h0041, rd_v);
    rx(8'h5A);
    chk("eop", 16'h0001, {15'h0000, endofpacket_o});
    chk("irq", 16'h0001, {15'h0000, irq_o});
    bus(1'b0, ufc_pkg::ADDR_STATUS, 16'h0000);
    chk("status", 16'h1080, rd_v & 16'h1080);
    bus(1'b0, ufc_pkg::ADDR_RXDATA, 16'h0000);
    chk("irq", 16'h0000, {15'h0000, irq_o});
    @(posedge clk_i);
    cts_n_i <= 1'b0;
    rx_frame_err_i <= 1'b1;
    rx_parity_err_i <= 1'b1;
    rx_break_i <= 1'b1;
    @(posedge clk_i);
    rx_frame_err_i <= 1'b0;
    rx_parity_err_i <= 1'b0;
    rx_break_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, ufc_pkg::ADDR_STATUS, 16'h0000);
    chk("status", 16'h0D07, rd_v & 16'h0D07);
    chk("irq", 16'h0001, {15'h0000, irq_o});
    bus(1'b1, ufc_pkg::ADDR_STATUS, 16'h0000);
    bus(1'b0, ufc_pkg::ADDR_STATUS, 16'h0000);
    chk("sticky", 16'h0800, rd_v & 16'h0D07);
    bus(1'b1, ufc_pkg::ADDR_TXDATA, 16'h0033);
    chk("tx write", 16'h0001, {15'h0000, tx_write_o});
    chk("tx char", 16'h0033, {8'h00, tx_char_o});
    @(posedge clk_i);
    #1 chk("ready", 16'h0000, {15'h0000, readyfordata_o});
    for (int i = 0; i < 10 && readyfordata_o !== 1'b1; i++) @(posedge clk_i);
    chk("ready", 16'h0001, {15'h0000, readyfordata_o});
    tally_and_finish();
  end
endmodule : tb_ufc_core
`default_nettype wire
